// ---- common/bwcs_pkg.sv ----
package bwcs_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned FAST_RC_START_NS = 5000;
    localparam int unsigned SLOW_RC_START_NS = 43000000;
    localparam int unsigned EXT_RST_MIN_NS = 120000;
    // Least times round up to whole cycles
    localparam int unsigned FAST_RC_START_CYC = (FAST_RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOW_RC_START_CYC = (SLOW_RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EXT_RST_MIN_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BOOT_SLOW_TICKS = 1024;
    localparam int unsigned NORMAL_WAKE_TICKS = 1024;
    localparam int unsigned FAST_WAKE_SYS_TICKS = 128;
    localparam int unsigned CNT_W = 24;

    // ----------------------------------------
    // Memory map of the core
    // ----------------------------------------
    localparam int unsigned PM_WORDS = 1536;
    localparam int unsigned PM_WIDTH = 14;
    localparam int unsigned PM_AW = 11;
    localparam logic [10:0] RESET_VEC = 11'h000;
    localparam logic [10:0] IRQ_VEC = 11'h010;
    localparam logic [10:0] PM_RSVD_FIRST = 11'h5F8;
    localparam int unsigned DM_BYTES = 88;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [8:0] OFS_CLKMODE = 9'h000;
    localparam logic [8:0] OFS_XTAL = 9'h004;
    localparam logic [8:0] OFS_TRIM = 9'h008;
    localparam logic [8:0] OFS_CTRL = 9'h00C;
    localparam logic [8:0] OFS_STATUS = 9'h010;
    localparam logic [8:0] OFS_IND_PTR = 9'h018;
    localparam logic [8:0] OFS_IND_DATA = 9'h01C;
    localparam logic [8:0] OFS_BITOP = 9'h020;
    localparam logic [8:0] OFS_DM_BASE = 9'h100;

    // Field positions
    localparam int unsigned CM_SRC_LSB = 0;
    localparam int unsigned CM_SLOW_EN = 2;
    localparam int unsigned CM_FAST_EN = 4;
    localparam int unsigned CM_DIV_LSB = 5;
    localparam int unsigned XT_EN = 7;
    localparam int unsigned CTRL_FAST_WAKE = 0;
    localparam int unsigned BIT_IDX_LSB = 0;
    localparam int unsigned BIT_POS_LSB = 8;
    localparam int unsigned BIT_VAL = 11;

    // Reset values
    localparam logic [7:0] CLKMODE_RST = 8'h14;
    localparam logic [7:0] XTAL_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Clock sources
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_FAST = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_RUN = 3'b001,
        ST_HALT = 3'b010,
        ST_SYSOFF = 3'b011,
        ST_STARTUP = 3'b100,
        ST_WAKE = 3'b101
    } bwcs_state_t;

    typedef struct packed {
        logic xtal_en;
        logic fast_en;
        logic slow_en;
        logic [1:0] src;
        logic [2:0] div;
    } bwcs_clk_t;

    typedef struct packed {
        logic load;
        logic [10:0] addr;
    } bwcs_fetch_t;

endpackage

// ---- core/bwcs_div.sv ----
`timescale 1ns/100ps
// Passes one tick out of every 2**div_sel input ticks
module bwcs_div
    import bwcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [2:0] div_sel,
    output logic tick_out
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] top;

    // Next count and wrap point
    always_comb begin
        top = 7'((8'h01 << div_sel) - 8'h01);
        cnt_d = cnt_q;
        tick_out = 1'b0;
        if (tick_in) begin
            if (cnt_q >= top) begin
                cnt_d = 7'h00;
                tick_out = 1'b1;
            end else begin
                cnt_d = cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- core/bwcs_top.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] Fast halt wake: 128 system clocks
// [RULE2] Fast full wake, fast RC: 5us+128 clocks
// [RULE3] Fast full wake, slow RC: 43ms+128 clocks
// [RULE4] Normal wake: 1024 slow RC periods
// [RULE5] Power-on boot holds core 1024 slow periods
// [RULE6] System clock is slow RC after boot
// [RULE7] Both RC oscillators enabled after boot
// [RULE8] Three oscillator enables, independently writable
// [RULE9] Clock mode picks source and divider
// [RULE10] Fetch starts at 0x00 after reset
// [RULE11] Taken interrupt vectors fetch to 0x10
// [RULE12] Program memory 1.5K words of 14 bits
// [RULE13] Top eight program words reserved, not user
// [RULE14] 88 data bytes, byte/bit/indirect access; the byte window reaches only bytes 0-63
// [RULE15] External reset held at least 120us
// [RULE16] Trim register for fast RC frequency
// [RULE17] Fast/normal wake setting applies next exit
module bwcs_top
    import bwcs_pkg::*;
#(
    parameter int unsigned SLOW_START_CYC = bwcs_pkg::SLOW_RC_START_CYC,
    parameter int unsigned EXT_RST_CYC = bwcs_pkg::EXT_RST_MIN_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_rst_pin_n,
    input wire logic wake_io_pin,
    input wire logic slow_rc_pin,
    input wire logic fast_rc_pin,
    input wire logic xtal_pin,
    input wire logic susp_exec_req,
    input wire logic susp_sys_req,
    input wire logic irq_take,
    output logic core_run,
    output bwcs_pkg::bwcs_fetch_t fetch,
    output bwcs_pkg::bwcs_clk_t clk_ctrl,
    output logic [7:0] fast_rc_trim
);
    import bwcs_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [3:0] sync3_q;
    logic ext_low;
    logic wake_tgl;
    logic slow_tick;
    logic raw_sys_edge;
    logic sys_tick;

    // Two stages, then a third for edges; all reset high so release shows no rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            sync3_q <= 4'hF;
        end else begin
            sync1_q <= {ext_rst_pin_n, wake_io_pin, slow_rc_pin, fast_rc_pin, xtal_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q[3:0];
        end
    end

    logic [7:0] clkmode_q;
    logic [7:0] clkmode_d;
    logic [7:0] xtal_q;
    logic [7:0] xtal_d;
    logic [7:0] trim_q;
    logic [7:0] trim_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [1:0] src;

    assign src = clkmode_q[CM_SRC_LSB +: 2];
    assign ext_low = !sync2_q[4];
    assign wake_tgl = sync2_q[3] ^ sync3_q[3];
    assign slow_tick = sync2_q[2] && !sync3_q[2];
    // Source mux; code 3 falls back to the slow RC
    assign raw_sys_edge = (src == SRC_FAST) ? (sync2_q[1] && !sync3_q[1]) :
                          (src == SRC_XTAL) ? (sync2_q[0] && !sync3_q[0]) : slow_tick; // [RULE9]

    bwcs_div u_sysdiv (
        .clk(clk),
        .rst_n(rst_n),
        .tick_in(raw_sys_edge),
        .div_sel(clkmode_q[CM_DIV_LSB +: 3]),
        .tick_out(sys_tick)
    );

    // ----------------------------------------
    // External reset filter
    // ----------------------------------------
    logic [CNT_W-1:0] erst_q;
    logic [CNT_W-1:0] erst_d;
    logic ext_hit;

    // Short glitches never restart the core
    always_comb begin
        erst_d = ext_low ? erst_q : '0;
        ext_hit = 1'b0;
        if (ext_low && erst_q != CNT_W'(EXT_RST_CYC)) begin
            erst_d = erst_q + 1'b1;
            ext_hit = (erst_q == CNT_W'(EXT_RST_CYC - 1)); // [RULE15]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            erst_q <= '0;
        end else begin
            erst_q <= erst_d;
        end
    end

    // ----------------------------------------
    // Boot and wake sequencer
    // ----------------------------------------
    bwcs_state_t st_q;
    bwcs_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic wslow_q;
    logic wslow_d;
    logic fsu_q;
    logic fsu_d;
    logic run_q;
    logic run_d;
    bwcs_fetch_t fetch_q;
    bwcs_fetch_t fetch_d;
    logic wake_tick;
    logic [CNT_W-1:0] wake_last;
    logic [CNT_W-1:0] start_last;

    assign wake_tick = wslow_q ? slow_tick : sys_tick;
    assign wake_last = wslow_q ? CNT_W'(NORMAL_WAKE_TICKS - 1) : CNT_W'(FAST_WAKE_SYS_TICKS - 1);
    assign start_last = fsu_q ? CNT_W'(FAST_RC_START_CYC - 1) : CNT_W'(SLOW_START_CYC - 1);

    // Next sequencer state
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wslow_d = wslow_q;
        fsu_d = fsu_q;
        run_d = run_q;
        fetch_d = fetch_q;
        fetch_d.load = 1'b0;
        if (ext_hit) begin
            st_d = ST_BOOT;
            cnt_d = '0;
            run_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_BOOT: begin
                    run_d = 1'b0;
                    if (slow_tick) begin
                        if (cnt_q == CNT_W'(BOOT_SLOW_TICKS - 1)) begin // [RULE5]
                            st_d = ST_RUN;
                            cnt_d = '0;
                            run_d = 1'b1;
                            fetch_d.load = 1'b1;
                            fetch_d.addr = RESET_VEC; // [RULE10]
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (susp_sys_req) begin
                        st_d = ST_SYSOFF;
                        run_d = 1'b0;
                    end else if (susp_exec_req) begin
                        st_d = ST_HALT;
                        run_d = 1'b0;
                    end else if (irq_take) begin
                        fetch_d.load = 1'b1;
                        fetch_d.addr = IRQ_VEC; // [RULE11]
                    end
                end
                ST_HALT, ST_SYSOFF: begin
                    if (wake_tgl) begin
                        cnt_d = '0;
                        // Setting is sampled at the exit itself
                        if (!ctrl_q[CTRL_FAST_WAKE]) begin // [RULE17]
                            st_d = ST_WAKE;
                            wslow_d = 1'b1; // [RULE4]
                        end else if (st_q == ST_SYSOFF && src != SRC_XTAL) begin
                            st_d = ST_STARTUP;
                            fsu_d = (src == SRC_FAST); // [RULE2] [RULE3]
                        end else begin
                            st_d = ST_WAKE;
                            wslow_d = 1'b0; // [RULE1]
                        end
                    end
                end
                ST_STARTUP: begin
                    if (cnt_q == start_last) begin // [RULE2] [RULE3]
                        st_d = ST_WAKE;
                        cnt_d = '0;
                        wslow_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (wake_tick) begin
                        if (cnt_q == wake_last) begin // [RULE1] [RULE4]
                            st_d = ST_RUN;
                            cnt_d = '0;
                            run_d = 1'b1;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    st_d = ST_BOOT;
                    cnt_d = '0;
                    run_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_BOOT;
            cnt_q <= '0;
            wslow_q <= 1'b1;
            fsu_q <= 1'b0;
            run_q <= 1'b0;
            fetch_q <= '{load: 1'b0, addr: RESET_VEC};
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wslow_q <= wslow_d;
            fsu_q <= fsu_d;
            run_q <= run_d;
            fetch_q <= fetch_d;
        end
    end

    // ----------------------------------------
    // Avalon-MM slave and registers
    // ----------------------------------------
    logic [7:0] dm [DM_BYTES];
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] iptr_q;
    logic [7:0] iptr_d;
    logic req;
    logic ack;
    logic [7:0] dm_idx;
    logic dm_sel;
    logic [7:0] ind_idx;
    logic [6:0] bit_idx;

    // Data window: one byte per aligned word
    function automatic logic [7:0] dm_index(input logic [8:0] a);
        dm_index = 8'(a[8:2]) - 8'(OFS_DM_BASE[8:2]);
    endfunction

    function automatic logic dm_ok(input logic [7:0] i);
        dm_ok = (i < 8'(DM_BYTES));
    endfunction

    assign req = avs_read || avs_write;
    assign ack = req && !wait_q;
    assign dm_idx = dm_index(avs_address);
    assign dm_sel = avs_address >= OFS_DM_BASE && dm_ok(dm_idx);
    // Pointer bytes above the memory read as zero and take no writes
    assign ind_idx = dm_ok(iptr_q) ? dm[iptr_q[6:0]] : 8'hFF; // [RULE14]
    assign bit_idx = avs_writedata[BIT_IDX_LSB +: 7];

    // One wait cycle, then the answer for one cycle
    always_comb begin
        wait_d = !(req && wait_q);
        rdata_d = rdata_q;
        clkmode_d = clkmode_q;
        xtal_d = xtal_q;
        trim_d = trim_q;
        ctrl_d = ctrl_q;
        iptr_d = iptr_q;
        if (req && wait_q) begin
            rdata_d = 32'h0000_0000;
            if (dm_sel) begin
                rdata_d[7:0] = dm[dm_idx[6:0]];
            end else begin
                unique case (avs_address)
                    OFS_CLKMODE: rdata_d[7:0] = clkmode_q;
                    OFS_XTAL: rdata_d[7:0] = xtal_q;
                    OFS_TRIM: rdata_d[7:0] = trim_q;
                    OFS_CTRL: rdata_d[7:0] = ctrl_q;
                    OFS_STATUS: rdata_d[7:0] = {3'h0, wslow_q, run_q, st_q};
                    OFS_IND_PTR: rdata_d[7:0] = iptr_q;
                    OFS_IND_DATA: rdata_d[7:0] = dm_ok(ind_idx) ? dm[ind_idx[6:0]] : 8'h00;
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
        if (ack && avs_write) begin
            unique case (avs_address)
                OFS_CLKMODE: clkmode_d = avs_writedata[7:0]; // [RULE8] [RULE9]
                OFS_XTAL: xtal_d = avs_writedata[7:0]; // [RULE8]
                OFS_TRIM: trim_d = avs_writedata[7:0]; // [RULE16]
                OFS_CTRL: ctrl_d = avs_writedata[7:0]; // [RULE17]
                OFS_IND_PTR: iptr_d = avs_writedata[7:0];
                default: ;
            endcase
        end
        // Any recognised reset brings the clock setup back
        if (ext_hit) begin
            clkmode_d = CLKMODE_RST; // [RULE6] [RULE7]
            xtal_d = XTAL_RST;
            trim_d = TRIM_RST;
            ctrl_d = CTRL_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            clkmode_q <= CLKMODE_RST;
            xtal_q <= XTAL_RST;
            trim_q <= TRIM_RST;
            ctrl_q <= CTRL_RST;
            iptr_q <= 8'h00;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            clkmode_q <= clkmode_d;
            xtal_q <= xtal_d;
            trim_q <= trim_d;
            ctrl_q <= ctrl_d;
            iptr_q <= iptr_d;
        end
    end

    // Data memory: byte, bit and indirect writes; no reset, like SRAM
    always_ff @(posedge clk) begin
        if (ack && avs_write) begin
            if (dm_sel) begin
                dm[dm_idx[6:0]] <= avs_writedata[7:0]; // [RULE14]
            end else if (avs_address == OFS_IND_DATA && dm_ok(ind_idx)) begin
                dm[ind_idx[6:0]] <= avs_writedata[7:0]; // [RULE14]
            end else if (avs_address == OFS_BITOP && dm_ok(8'(bit_idx))) begin
                dm[bit_idx][avs_writedata[BIT_POS_LSB +: 3]] <= avs_writedata[BIT_VAL]; // [RULE14]
            end
        end
    end

    // ----------------------------------------
    // Oscillator enables and outputs
    // ----------------------------------------
    bwcs_clk_t clk_d;
    bwcs_clk_t clk_q;
    logic awake;

    // Full suspend stops all; boot, start-up and normal wake force their counting source on
    always_comb begin
        awake = (st_q != ST_SYSOFF);
        clk_d.xtal_en = xtal_q[XT_EN] && awake; // [RULE8]
        clk_d.fast_en = (clkmode_q[CM_FAST_EN] && awake) || (st_q == ST_STARTUP && fsu_q);
        clk_d.slow_en = (clkmode_q[CM_SLOW_EN] && awake) || st_q == ST_BOOT ||
                        (st_q == ST_WAKE && wslow_q) || (st_q == ST_STARTUP && !fsu_q);
        clk_d.src = src; // [RULE9]
        clk_d.div = clkmode_q[CM_DIV_LSB +: 3];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_q <= '{xtal_en: 1'b0, fast_en: 1'b1, slow_en: 1'b1, src: SRC_SLOW, div: 3'h0};
        end else begin
            clk_q <= clk_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign core_run = run_q;
    assign fetch = fetch_q;
    assign clk_ctrl = clk_q;
    assign fast_rc_trim = trim_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_boot_end;
        st_q == ST_BOOT && !ext_hit && slow_tick && cnt_q == 24'd1023;
    endsequence

    sequence s_wr(logic [8:0] a);
        avs_write && !wait_q && avs_address == a;
    endsequence

    a_boot_release: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
        s_boot_end |=> run_q && st_q == ST_RUN)
        else $error("core not released after boot count");
    a_reset_vector: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        s_boot_end |=> fetch_q.load && fetch_q.addr == 11'h000)
        else $error("boot fetch not at reset vector");
    a_irq_vector: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        st_q == ST_RUN && irq_take && !susp_sys_req && !susp_exec_req && !ext_hit
        |=> fetch_q.load && fetch_q.addr == 11'h010)
        else $error("interrupt fetch not at 0x10");
    a_fast_halt_wake: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        st_q == ST_WAKE && !wslow_q && sys_tick && cnt_q == 24'd127 && !ext_hit
        |=> run_q && st_q == ST_RUN && cnt_q == 24'd0)
        else $error("fast wake not after 128 clocks");
    a_fast_rc_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        st_q == ST_STARTUP && fsu_q && cnt_q == 24'd1249 && !ext_hit
        |=> st_q == ST_WAKE && cnt_q == 24'd0 && !wslow_q)
        else $error("fast RC start-up wait wrong");
    a_slow_rc_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        st_q == ST_SYSOFF && wake_tgl && ctrl_q[0] && src == SRC_SLOW && !ext_hit
        |=> st_q == ST_STARTUP && !fsu_q && cnt_q == 24'd0)
        else $error("slow RC start-up not entered");
    a_normal_wake: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        st_q == ST_WAKE && wslow_q && slow_tick && cnt_q == 24'd1023 && !ext_hit
        |=> run_q && st_q == ST_RUN)
        else $error("normal wake not after 1024 slow periods");
    a_wake_select: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
        (st_q == ST_HALT || st_q == ST_SYSOFF) && wake_tgl && !ext_hit
        |=> wslow_q == !$past(ctrl_q[0]) || st_q == ST_STARTUP)
        else $error("wake timing ignores setting");
    a_boot_clocks: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6] [RULE7]
        ext_hit |=> ##1 clk_q.src == 2'h0 && clk_q.fast_en && clk_q.slow_en)
        else $error("clock setup wrong after reset");
    a_osc_enable: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        s_wr(9'h000) ##1 (st_q == ST_RUN && !ext_hit) |=> clk_q.fast_en == $past(avs_writedata[4], 2))
        else $error("fast RC enable not following register");
    a_trim_write: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
        s_wr(9'h008) && !ext_hit |=> fast_rc_trim == $past(avs_writedata[7:0]))
        else $error("trim register not written");
    a_ext_filter: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
        ext_hit |-> $past(ext_low, 1) && erst_q == 24'(EXT_RST_CYC - 1))
        else $error("external reset taken too early");
    a_fetch_range: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        fetch_q.load |-> fetch_q.addr < 11'(PM_WORDS))
        else $error("fetch outside program memory");
endmodule

// ---- sim/bwcs_osc_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Oscillator pins
// ----------------------------------------
module bwcs_osc_model
    import bwcs_pkg::*;
(
    input wire logic clk,
    input wire bwcs_pkg::bwcs_clk_t en,
    output logic slow_rc_pin,
    output logic fast_rc_pin,
    output logic xtal_pin
);
    logic [1:0] ph;
    // Slow edge every 4 clocks, others every 2; a disabled one stands still
    initial begin
        {ph, slow_rc_pin, fast_rc_pin, xtal_pin} = '0;
        forever begin
            @(posedge clk);
            ph <= ph + 2'h1;
            if (en.slow_en) slow_rc_pin <= ph[1];
            if (en.fast_en) fast_rc_pin <= ~fast_rc_pin;
            if (en.xtal_en) xtal_pin <= ~xtal_pin;
        end
    end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import bwcs_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, ext_rst_pin_n, wake_io_pin;
    logic slow_rc_pin, fast_rc_pin, xtal_pin, susp_exec_req, susp_sys_req, irq_take, core_run;
    logic [8:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] fast_rc_trim;
    bwcs_fetch_t fetch;
    bwcs_clk_t clk_ctrl;
    int mismatches, n_tests, tnum;

    // Short start-up and reset counts keep the run brief
    bwcs_top #(.SLOW_START_CYC(200), .EXT_RST_CYC(50)) dut (.clk, .rst_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .ext_rst_pin_n, .wake_io_pin, .slow_rc_pin, .fast_rc_pin, .xtal_pin, .susp_exec_req,
        .susp_sys_req, .irq_take, .core_run, .fetch, .clk_ctrl, .fast_rc_trim);
    bwcs_osc_model osc (.clk, .en(clk_ctrl), .slow_rc_pin, .fast_rc_pin, .xtal_pin);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low, then one idle edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        // No local limit: only the watchdog ends a hung request
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // Counts cycles until the core may run; the count must land in [lo, hi)
    task automatic wait_run(input int lo, input int hi);
        int n;
        n = 0;
        while (core_run !== 1'b1 && n < hi) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= lo && n < hi), 32'h1);
    endtask

    task automatic nap(input logic sys, input int lo, input int hi);
        susp_exec_req <= ~sys;
        susp_sys_req <= sys;
        @(posedge clk);
        {susp_exec_req, susp_sys_req} <= 2'b00;
        repeat (4) @(posedge clk);
        chk(32'(core_run), 32'h0);
        wake_io_pin <= ~wake_io_pin;
        wait_run(lo, hi);
    endtask

    task automatic done();
        tnum++;
        $display("test %0d done", tnum);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 15500 cycles of the tests
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rst_n, avs_read, avs_write, susp_exec_req, susp_sys_req, irq_take} = '0;
        {avs_address, avs_writedata, ext_rst_pin_n, wake_io_pin} = {41'h0, 2'b10};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(4092, 4112);
        chk(32'(fetch), {20'h0, 1'b1, RESET_VEC});
        chk(32'(clk_ctrl), 32'h60);
        done();
        rd(OFS_CLKMODE, 32'h14);
        rd(OFS_XTAL, 32'h0);
        rd(OFS_TRIM, 32'h80);
        rd(9'h014, 32'h0);
        wr(OFS_XTAL, 32'h80);
        wr(OFS_CLKMODE, 32'h25);
        repeat (2) @(posedge clk);
        chk(32'(clk_ctrl), 32'hA9);
        wr(OFS_XTAL, 32'h0);
        wr(OFS_TRIM, 32'h5A);
        chk(32'(fast_rc_trim), 32'h5A);
        done();
        // Indirect through byte 0 reaches the top byte; then one bit set
        wr(OFS_DM_BASE, 32'h57);
        wr(OFS_IND_PTR, 32'h0);
        wr(OFS_IND_DATA, 32'hA7);
        rd(OFS_IND_DATA, 32'hA7);
        wr(OFS_DM_BASE + 9'h004, 32'h0);
        wr(OFS_BITOP, 32'hB01);
        rd(OFS_DM_BASE + 9'h004, 32'h08);
        done();
        irq_take <= 1'b1;
        @(posedge clk);
        irq_take <= 1'b0;
        @(posedge clk);
        chk(32'(fetch), {20'h0, 1'b1, IRQ_VEC});
        chk(32'(fetch.addr < PM_RSVD_FIRST), 32'h1);
        done();
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CLKMODE, 32'h15);
        nap(1'b0, 254, 272);
        nap(1'b1, 1504, 1522);
        wr(OFS_CLKMODE, 32'h14);
        nap(1'b1, 708, 728);
        // Crystal source halved: no start-up wait, 128 ticks of 4 cycles
        wr(OFS_XTAL, 32'h80);
        wr(OFS_CLKMODE, 32'h36);
        nap(1'b1, 510, 528);
        wr(OFS_CTRL, 32'h0);
        nap(1'b0, 4092, 4112);
        done();
        // A short pin pulse is ignored, a long one restarts the boot hold
        ext_rst_pin_n <= 1'b0;
        repeat (20) @(posedge clk);
        ext_rst_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(core_run), 32'h1);
        ext_rst_pin_n <= 1'b0;
        repeat (60) @(posedge clk);
        chk(32'(core_run), 32'h0);
        ext_rst_pin_n <= 1'b1;
        // Boot count restarted eight cycles before the pin was released
        wait_run(4080, 4100);
        done();
        give_verdict();
    end
endmodule
